//--- logic/hsfs_regs.vh
// register map, field positions and timing counts of the fault sequencer
`ifndef HSFS_REGS_VH
`define HSFS_REGS_VH
// register offsets
`define HSFS_SWITCH_CONTROL 8'h00
`define HSFS_FAULT_HISTORY 8'h04
`define HSFS_LIVE_CONDITION 8'h1e
// switch_control fields
`define HSFS_CTL_OV_RETRY 0
`define HSFS_CTL_OC_RETRY 2
`define HSFS_CTL_FET_ON 3
// fault_history fields
`define HSFS_FLT_OV 0
`define HSFS_FLT_OC 2
`define HSFS_FLT_MASK 8'h05
// live_condition fields
`define HSFS_ST_OV 0
`define HSFS_ST_OC 2
`define HSFS_ST_PGOOD 3
`define HSFS_ST_PBAD 4
// reset values
`define HSFS_FLT_RESET 8'h00
`define HSFS_CTL_RESET 8'h00
// i2c slave address, arbitrary value
`define HSFS_I2C_ADDR 7'h2a
// timing
`define HSFS_CLK_MHZ 200
`define HSFS_OV_FILT_US 25
`define HSFS_OV_QUAL_MS 50
`define HSFS_OV_FILT_CYC (`HSFS_OV_FILT_US * `HSFS_CLK_MHZ)
`define HSFS_OV_QUAL_CYC (`HSFS_OV_QUAL_MS * 1000 * `HSFS_CLK_MHZ)
`define HSFS_COOL_LAST 8'hff
`endif

//--- logic/hsfs_filt.v
// level filter: output rises once the input has held high past a limit
`timescale 1ns/1ps
module hsfs_filt #(
    parameter W = 24
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // level and limit
    input wire level,
    input wire [W-1:0] limit,
    // filtered level
    output reg held
);
    reg [W-1:0] cnt_r;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= {W{1'b0}};
            held <= 1'b0;
        end else if (!level) begin
            cnt_r <= {W{1'b0}};
            held <= 1'b0;
        end else if (cnt_r >= limit) begin
            held <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule // hsfs_filt

//--- logic/hsfs_i2c.v
// i2c slave: pointer byte, then byte writes or reads with auto increment
`timescale 1ns/1ps
`include "hsfs_regs.vh"
module hsfs_i2c (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // bus pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_oe,
    // register side
    output reg [7:0] ptr,
    input wire [7:0] rd_data,
    output reg wr_stb,
    output reg [7:0] wr_addr,
    output reg [7:0] wr_data
);
    localparam S_IDLE = 3'd0;
    localparam S_ADDR = 3'd1;
    localparam S_PTR = 3'd2;
    localparam S_WR = 3'd3;
    localparam S_RD = 3'd4;

    reg [2:0] scl_s, sda_s;
    reg [2:0] st_r, cnt_r;
    reg [7:0] sh_r, tx_r;
    reg sack_r, mack_r;
    wire [7:0] byte_in = {sh_r[6:0], sda_s[1]};
    wire rise = scl_s[1] & ~scl_s[2];
    wire fall = ~scl_s[1] & scl_s[2];
    wire start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
    wire stop = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            st_r <= S_IDLE;
            cnt_r <= 3'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            sack_r <= 1'b0;
            mack_r <= 1'b0;
            sda_oe <= 1'b0;
            ptr <= 8'h00;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            // stage one only feeds stage two; edges use stages two and three
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            wr_stb <= 1'b0;
            if (start) begin
                st_r <= S_ADDR;
                cnt_r <= 3'h0;
                sack_r <= 1'b0;
                mack_r <= 1'b0;
            end else if (stop) begin
                st_r <= S_IDLE;
                sack_r <= 1'b0;
                mack_r <= 1'b0;
                sda_oe <= 1'b0;
            end else if (rise && st_r != S_IDLE) begin
                if (sack_r || mack_r) begin
                    sack_r <= 1'b0;
                    mack_r <= 1'b0;
                    tx_r <= rd_data;
                    // a nack from the master ends the read
                    if (mack_r && sda_s[1])
                        st_r <= S_IDLE;
                end else begin
                    sh_r <= byte_in;
                    cnt_r <= cnt_r + 3'h1;
                    if (cnt_r == 3'h7) begin
                        case (st_r)
                            S_ADDR: begin
                                if (byte_in[7:1] == `HSFS_I2C_ADDR) begin
                                    sack_r <= 1'b1;
                                    st_r <= byte_in[0] ? S_RD : S_PTR;
                                end else begin
                                    st_r <= S_IDLE;
                                end
                            end
                            S_PTR: begin
                                ptr <= byte_in;
                                sack_r <= 1'b1;
                                st_r <= S_WR;
                            end
                            S_WR: begin
                                wr_stb <= 1'b1;
                                wr_addr <= ptr;
                                wr_data <= byte_in;
                                ptr <= ptr + 8'h01;
                                sack_r <= 1'b1;
                            end
                            S_RD: begin
                                ptr <= ptr + 8'h01;
                                mack_r <= 1'b1;
                            end
                            default: st_r <= S_IDLE;
                        endcase
                    end
                end
            end else if (fall) begin
                if (sack_r)
                    sda_oe <= 1'b1;
                else if (st_r == S_RD && !mack_r)
                    sda_oe <= ~tx_r[~cnt_r];
                else
                    sda_oe <= 1'b0;
            end
        end
    end
endmodule // hsfs_i2c

//--- logic/hsfs_top.v
// hot swap fault sequencer: power good, breaker timer, overvoltage
`timescale 1ns/1ps
`include "hsfs_regs.vh"
// Notes on behaviour
// R1: power good only after feedback high and gate enhancement reached.
// R2: power good drives its pin and a status bit readable over i2c.
// R3: no power-bad during slew-limited start where feedback trips first.
// R4: overcurrent fault when current limiting outlasts the breaker time.
// R5: timer charges while limiting; at upper threshold the switch turns off.
// R6: limiting ends before upper threshold: timer discharges, no fault.
// R7: after overcurrent, discharge to lower threshold then 256 up/down cycles.
// R8: final fall re-enables only with retry set or fault bit cleared.
// R9: overvoltage held over 25 us declares a fault and turns gate off.
// R10: overvoltage sets status present bit and latched fault bit.
// R11: 50 ms below threshold re-enables unless overvoltage retry is clear.
// R12: at reset faults clear and control loads from nonvolatile copy.
// R13: fault with retry low keeps gate off until its bit is cleared.
// R14: host writing zero to a fault bit clears that fault.
// R15: cool-down cycles counted, cleared per fault, end at terminal count.
module hsfs_top #(
    parameter [23:0] OV_FILT_CYC = `HSFS_OV_FILT_CYC,
    parameter [23:0] OV_QUAL_CYC = `HSFS_OV_QUAL_CYC
) (
    // clock and reset
    input wire CLK,
    input wire RST_B,
    // comparator pins
    input wire OUTPUT_FEEDBACK_SENSE,
    input wire GATE_ENHANCED,
    input wire CURRENT_LIMITING,
    input wire OVERVOLTAGE_SENSE,
    input wire TIMER_ABOVE_HIGH,
    input wire TIMER_BELOW_LOW,
    // nonvolatile control copy
    input wire [7:0] NV_CONTROL,
    // i2c pins
    input wire SCL_IN,
    input wire SDA_IN,
    output reg SDA_OUT,
    output wire SDA_OE,
    // switch and timer drive
    output reg GATE_ON,
    output reg TIMER_CHARGE,
    output reg TIMER_DISCHARGE,
    // power status pins
    output reg POWER_GOOD_OUTPUT_PIN,
    output reg POWER_BAD
);
    localparam OC_RUN = 3'd0;
    localparam OC_COOL = 3'd1;
    localparam OC_UP = 3'd2;
    localparam OC_DN = 3'd3;
    localparam OC_HOLD = 3'd4;

    // pin synchronisers, second stage is the only reader of the first
    reg [5:0] pin_s1_r, pin_s2_r;
    wire fb = pin_s2_r[0];
    wire enh = pin_s2_r[1];
    wire ilim = pin_s2_r[2];
    wire ov = pin_s2_r[3];
    wire t_hi = pin_s2_r[4];
    wire t_lo = pin_s2_r[5];

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin_s1_r <= 6'h00;
            pin_s2_r <= 6'h00;
        end else begin
            pin_s1_r <= {TIMER_BELOW_LOW, TIMER_ABOVE_HIGH,
                OVERVOLTAGE_SENSE, CURRENT_LIMITING, GATE_ENHANCED,
                OUTPUT_FEEDBACK_SENSE};
            pin_s2_r <= pin_s1_r;
        end
    end

    // register bus
    wire [7:0] ptr;
    wire wr_stb;
    wire [7:0] wr_addr, wr_data;
    reg [7:0] rd_data;

    hsfs_i2c u_i2c (
        .clk(CLK),
        .rst_b(RST_B),
        .scl_in(SCL_IN),
        .sda_in(SDA_IN),
        .sda_oe(SDA_OE),
        .ptr(ptr),
        .rd_data(rd_data),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    // overvoltage filters
    wire ov_long, ov_clear;

    hsfs_filt #(.W(24)) u_ov_filt (
        .clk(CLK),
        .rst_b(RST_B),
        .level(ov),
        .limit(OV_FILT_CYC),
        .held(ov_long)
    );

    hsfs_filt #(.W(24)) u_ov_qual (
        .clk(CLK),
        .rst_b(RST_B),
        .level(~ov),
        .limit(OV_QUAL_CYC),
        .held(ov_clear)
    );

    reg [7:0] ctrl_r, fault_r, fault_nxt;
    reg por_done_r;
    reg ov_long_d_r, ov_blk_r, ov_blk_nxt;
    reg [2:0] oc_st_r, oc_st_nxt;
    reg [7:0] cool_cnt_r, cool_cnt_nxt;
    reg oc_set, t_up, t_dn;
    reg pg_arm_r;
    wire ov_set = ov_long & ~ov_long_d_r;
    wire oc_ok = ctrl_r[`HSFS_CTL_OC_RETRY] | ~fault_r[`HSFS_FLT_OC];
    wire ov_ok = ctrl_r[`HSFS_CTL_OV_RETRY] | ~fault_r[`HSFS_FLT_OV];
    wire gate_nxt = por_done_r & ctrl_r[`HSFS_CTL_FET_ON] & ~ov_blk_nxt &
        (oc_st_nxt == OC_RUN);
    wire fault_wr = wr_stb && wr_addr == `HSFS_FAULT_HISTORY;

    // breaker timer sequencing
    always @* begin
        oc_st_nxt = oc_st_r;
        cool_cnt_nxt = cool_cnt_r;
        oc_set = 1'b0;
        t_up = 1'b0;
        t_dn = 1'b1;
        case (oc_st_r)
            OC_RUN: begin
                if (ilim && GATE_ON) begin
                    t_up = 1'b1; // R5
                    t_dn = 1'b0;
                end
                // a short limiting burst only ramps down again
                if (ilim && GATE_ON && t_hi) begin // R6
                    oc_set = 1'b1; // R4
                    oc_st_nxt = OC_COOL; // R5
                    cool_cnt_nxt = 8'h00; // R15
                end
            end
            OC_COOL: begin
                if (t_lo)
                    oc_st_nxt = OC_UP; // R7
            end
            OC_UP: begin
                t_up = 1'b1;
                t_dn = 1'b0;
                if (t_hi)
                    oc_st_nxt = OC_DN;
            end
            OC_DN: begin
                if (t_lo) begin
                    if (cool_cnt_r == `HSFS_COOL_LAST) begin // R15
                        oc_st_nxt = oc_ok ? OC_RUN : OC_HOLD; // R8
                    end else begin
                        cool_cnt_nxt = cool_cnt_r + 8'h01; // R7
                        oc_st_nxt = OC_UP;
                    end
                end
            end
            OC_HOLD: begin
                if (oc_ok)
                    oc_st_nxt = OC_RUN; // R13
            end
            default: oc_st_nxt = OC_RUN;
        endcase
    end

    // overvoltage gate block and fault history update
    always @* begin
        ov_blk_nxt = ov_blk_r;
        if (ov_long)
            ov_blk_nxt = 1'b1; // R9
        else if (ov_clear && ov_ok)
            ov_blk_nxt = 1'b0; // R11 R13
        fault_nxt = fault_r;
        if (fault_wr)
            fault_nxt = fault_r & wr_data; // R14
        // a new fault beats a clear in the same cycle
        if (ov_set)
            fault_nxt[`HSFS_FLT_OV] = 1'b1; // R10
        if (oc_set)
            fault_nxt[`HSFS_FLT_OC] = 1'b1; // R4
        fault_nxt = fault_nxt & `HSFS_FLT_MASK;
    end

    // read mux
    always @* begin
        case (ptr)
            `HSFS_SWITCH_CONTROL: rd_data = ctrl_r;
            `HSFS_FAULT_HISTORY: rd_data = fault_r;
            `HSFS_LIVE_CONDITION: begin
                rd_data = 8'h00;
                rd_data[`HSFS_ST_OV] = ov_long; // R10
                rd_data[`HSFS_ST_OC] = oc_st_r != OC_RUN;
                rd_data[`HSFS_ST_PGOOD] = POWER_GOOD_OUTPUT_PIN; // R2
                rd_data[`HSFS_ST_PBAD] = POWER_BAD;
            end
            default: rd_data = 8'h00;
        endcase
    end

    // control, faults and sequencing state
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_r <= `HSFS_CTL_RESET;
            fault_r <= `HSFS_FLT_RESET; // R12
            por_done_r <= 1'b0;
            ov_long_d_r <= 1'b0;
            ov_blk_r <= 1'b0;
            oc_st_r <= OC_RUN;
            cool_cnt_r <= 8'h00;
        end else begin
            // nonvolatile copy is taken on the first edge after release
            por_done_r <= 1'b1;
            if (!por_done_r)
                ctrl_r <= NV_CONTROL; // R12
            else if (wr_stb && wr_addr == `HSFS_SWITCH_CONTROL)
                ctrl_r <= wr_data;
            fault_r <= fault_nxt;
            ov_long_d_r <= ov_long;
            ov_blk_r <= ov_blk_nxt;
            oc_st_r <= oc_st_nxt;
            cool_cnt_r <= cool_cnt_nxt;
        end
    end

    // outputs and power good qualification
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SDA_OUT <= 1'b0;
            GATE_ON <= 1'b0;
            TIMER_CHARGE <= 1'b0;
            TIMER_DISCHARGE <= 1'b0;
            POWER_GOOD_OUTPUT_PIN <= 1'b0;
            POWER_BAD <= 1'b0;
            pg_arm_r <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
            GATE_ON <= gate_nxt; // R9 R13
            TIMER_CHARGE <= t_up;
            TIMER_DISCHARGE <= t_dn; // R6
            // once armed the pin follows feedback, riding out enhancement dips
            if (!GATE_ON)
                pg_arm_r <= 1'b0;
            else if (fb && enh)
                pg_arm_r <= 1'b1; // R1
            POWER_GOOD_OUTPUT_PIN <= fb & (pg_arm_r | enh) & GATE_ON; // R1 R2
            // feedback trips before enhancement on a slow start
            POWER_BAD <= GATE_ON & enh & ~fb; // R3
        end
    end
endmodule // hsfs_top

//--- dv/hsfs_sva.sv
// port checker of the hot swap fault sequencer
`timescale 1ns/1ps
module hsfs_sva #(
    parameter [23:0] OV_FILT_CYC = 24'h001388,
    parameter [23:0] OV_QUAL_CYC = 24'h989680
) (
    // clock and reset
    input wire CLK,
    input wire RST_B,
    // comparators
    input wire CURRENT_LIMITING,
    input wire OVERVOLTAGE_SENSE,
    input wire TIMER_ABOVE_HIGH,
    // drives
    input wire GATE_ON,
    input wire TIMER_CHARGE,
    input wire TIMER_DISCHARGE,
    input wire POWER_GOOD_OUTPUT_PIN,
    input wire POWER_BAD
);
    reg [23:0] ov_n_r;
    // counts raw high cycles; margin covers the input synchronisers
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) ov_n_r <= 24'h0;
        else ov_n_r <= OVERVOLTAGE_SENSE ? ov_n_r + 24'h1 : 24'h0;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_pg_gate: assert property (
        $rose(POWER_GOOD_OUTPUT_PIN) |-> GATE_ON)
        else $error("power good rose with gate off");
    a_pg_drop: assert property (
        !GATE_ON [*3] |-> !POWER_GOOD_OUTPUT_PIN)
        else $error("power good held with gate off");
    a_pbad_gate: assert property (
        POWER_BAD |-> GATE_ON)
        else $error("power bad with gate off");
    a_tmr_excl: assert property (
        !(TIMER_CHARGE && TIMER_DISCHARGE))
        else $error("timer charge and discharge together");
    a_oc_trip: assert property (
        (CURRENT_LIMITING && TIMER_ABOVE_HIGH && GATE_ON) [*4]
        |-> ##[0:3] !GATE_ON)
        else $error("breaker did not open");
    a_chg_limit: assert property (
        (CURRENT_LIMITING && GATE_ON) [*5] |-> TIMER_CHARGE)
        else $error("timer not charging while limiting");
    a_dis_run: assert property (
        (!CURRENT_LIMITING && GATE_ON) [*5] |-> TIMER_DISCHARGE)
        else $error("timer not discharging");
    a_ov_trip: assert property (
        ov_n_r > OV_FILT_CYC + 24'd10 |-> !GATE_ON)
        else $error("gate on through overvoltage");
    a_rst_quiet: assert property (
        $rose(RST_B) |-> !GATE_ON && !TIMER_CHARGE)
        else $error("drive active at reset release");
endmodule // hsfs_sva
bind hsfs_top hsfs_sva #(.OV_FILT_CYC(OV_FILT_CYC),
    .OV_QUAL_CYC(OV_QUAL_CYC)) hsfs_sva_inst (
    .CLK(CLK), .RST_B(RST_B), .CURRENT_LIMITING(CURRENT_LIMITING),
    .OVERVOLTAGE_SENSE(OVERVOLTAGE_SENSE),
    .TIMER_ABOVE_HIGH(TIMER_ABOVE_HIGH), .GATE_ON(GATE_ON),
    .TIMER_CHARGE(TIMER_CHARGE), .TIMER_DISCHARGE(TIMER_DISCHARGE),
    .POWER_GOOD_OUTPUT_PIN(POWER_GOOD_OUTPUT_PIN), .POWER_BAD(POWER_BAD));

//--- dv/hsfs_fet.sv
// behavioural pass switch and timer capacitor
`timescale 1ns/1ps
module hsfs_fet (
    // clock
    input wire clk,
    // drive from the sequencer
    input wire gate_on,
    input wire chg,
    input wire dis,
    // comparator outputs
    output reg fb,
    output reg enh,
    output reg tah,
    output reg tbl
);
    reg [3:0] g_r = 4'h0;
    reg [3:0] c_r = 4'h0;
    always @(posedge clk) begin
        g_r <= !gate_on ? 4'h0 : (g_r == 4'hf ? g_r : g_r + 4'h1);
        if (chg && c_r != 4'ha) c_r <= c_r + 4'h1;
        else if (dis && c_r != 4'h0) c_r <= c_r - 4'h1;
    end
    // slew-limited start: feedback crosses well before enhancement
    always @* begin
        fb = g_r > 4'h3;
        enh = g_r > 4'h9;
        tah = c_r > 4'h7;
        tbl = c_r < 4'h2;
    end
endmodule // hsfs_fet

//--- dv/testbench.sv
// self-checking bench of the hot swap fault sequencer
`timescale 1ns/1ps
`include "hsfs_regs.vh"
module testbench;
    reg clk, rst_b, lim, ov, scl, sdm;
    reg [7:0] nv, q, v;
    reg chg_q;
    wire fb, enh, tah, tbl, sda_oe, gate, chg, dis, pg, pbad, sda_out;
    wire sda = sdm & ~sda_oe;
    wire [2:0] w = {pg, fb, gate};
    integer fails, n_checks, cool, pbn, nw, i, k;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    hsfs_top #(.OV_FILT_CYC(24'd20), .OV_QUAL_CYC(24'd50)) hsfs_top_inst (
        .CLK(clk), .RST_B(rst_b), .OUTPUT_FEEDBACK_SENSE(fb),
        .GATE_ENHANCED(enh), .CURRENT_LIMITING(lim),
        .OVERVOLTAGE_SENSE(ov), .TIMER_ABOVE_HIGH(tah),
        .TIMER_BELOW_LOW(tbl), .NV_CONTROL(nv), .SCL_IN(scl),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .GATE_ON(gate),
        .TIMER_CHARGE(chg), .TIMER_DISCHARGE(dis),
        .POWER_GOOD_OUTPUT_PIN(pg), .POWER_BAD(pbad));
    hsfs_fet hsfs_fet_inst (.clk(clk), .gate_on(gate), .chg(chg),
        .dis(dis), .fb(fb), .enh(enh), .tah(tah), .tbl(tbl));
    always @(posedge clk) begin
        chg_q <= chg;
        if (chg && !chg_q && !gate) cool <= cool + 1;
        if (pbad) pbn <= pbn + 1;
    end
    task wt(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task check(input [15:0] s, input [15:0] e);
        n_checks = n_checks + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task conclude;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task ws(input integer s, input b, input integer lm);
        nw = 0;
        while (w[s] !== b && nw < lm) begin
            wt(1);
            nw = nw + 1;
        end
        if (nw >= lm) begin
            fails = fails + 1;
            conclude;
        end
    endtask
    task bt(input b, output r);
        sdm <= b;
        wt(5);
        scl <= 1'b1;
        wt(5);
        r = sda;
        scl <= 1'b0;
        wt(1);
    endtask
    task xb(input [7:0] d, input ma, output [7:0] o, output a);
        integer j;
        reg r;
        for (j = 7; j >= 0; j = j - 1) begin
            bt(d[j], r);
            o[j] = r;
        end
        bt(ma, a);
    endtask
    task st;
        sdm <= 1'b1;
        wt(5);
        scl <= 1'b1;
        wt(5);
        sdm <= 1'b0;
        wt(5);
        scl <= 1'b0;
        wt(1);
    endtask
    task sp;
        sdm <= 1'b0;
        wt(5);
        scl <= 1'b1;
        wt(5);
        sdm <= 1'b1;
        wt(5);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        reg [7:0] o;
        reg c;
        st;
        xb({`HSFS_I2C_ADDR, 1'b0}, 1'b1, o, c);
        xb(a, 1'b1, o, c);
        xb(d, 1'b1, o, c);
        sp;
    endtask
    task rd(input [7:0] a, output [7:0] r);
        reg [7:0] o;
        reg c;
        st;
        xb({`HSFS_I2C_ADDR, 1'b0}, 1'b1, o, c);
        xb(a, 1'b1, o, c);
        st;
        xb({`HSFS_I2C_ADDR, 1'b1}, 1'b1, o, c);
        xb(8'hff, 1'b1, r, c);
        sp;
    endtask
    initial begin
        fails = 0; n_checks = 0; cool = 0; pbn = 0; chg_q = 1'b0;
        rst_b = 1'b0; lim = 1'b0; ov = 1'b0; scl = 1'b1; sdm = 1'b1;
        v = $urandom(40797);
        nv = (v & 8'hf2) | 8'h0d;
        wt(20);
        rst_b <= 1'b1;
        ws(1, 1'b1, 100);
        check(pg, 1'b0);
        ws(2, 1'b1, 100);
        check(enh, 1'b1);
        rd(`HSFS_LIVE_CONDITION, q);
        check(q[3], 1'b1);
        check(pbn, 0);
        rd(`HSFS_SWITCH_CONTROL, q);
        check(q, nv);
        rd(`HSFS_FAULT_HISTORY, q);
        check(q, 8'h00);
        rd(8'h10, q);
        check(q, 8'h00);
        // the data pin is open drain: only its enable may ever move
        check(sda_out, 1'b0);
        $display("test startup done");
        lim <= 1'b1;
        wt(3);
        lim <= 1'b0;
        wt(40);
        check(gate, 1'b1);
        rd(`HSFS_FAULT_HISTORY, q);
        check(q, 8'h00);
        $display("test short limit done");
        // second pass clears oc retry, so the gate must wait for the host
        for (k = 0; k < 2; k = k + 1) begin
            wr(`HSFS_SWITCH_CONTROL, k ? nv & 8'hfb : nv);
            cool = 0;
            lim <= 1'b1;
            ws(0, 1'b0, 100);
            lim <= 1'b0;
            rd(`HSFS_FAULT_HISTORY, q);
            check(q, 8'h04);
            if (k == 0) begin
                ws(0, 1'b1, 20000);
                check(cool, 256);
            end else begin
                for (i = 0; i < 20000 && cool < 256; i = i + 1) wt(1);
                wt(50);
                check(gate, 1'b0);
            end
            wr(`HSFS_FAULT_HISTORY, 8'h00);
            ws(0, 1'b1, 100);
            check(gate, 1'b1);
            $display("test overcurrent %0d done", k);
        end
        wr(`HSFS_SWITCH_CONTROL, nv);
        v = $urandom;
        ov <= 1'b1;
        wt(v[2:0] + 1);
        ov <= 1'b0;
        wt(30);
        check(gate, 1'b1);
        ov <= 1'b1;
        ws(0, 1'b0, 200);
        rd(`HSFS_LIVE_CONDITION, q);
        check(q[0], 1'b1);
        rd(`HSFS_FAULT_HISTORY, q);
        check(q[0], 1'b1);
        ov <= 1'b0;
        ws(0, 1'b1, 1000);
        check(nw >= 50, 1'b1);
        $display("test overvoltage done");
        conclude;
    end
endmodule // testbench
